// ### ise_pkg.sv
// Shared types and constants for the integer scheduler and execution cluster
package ise_pkg;
    localparam int NARCH = 16;        // Architectural integer registers
    localparam int NPHYS = 32;        // Physical registers
    localparam int NQ = 16;           // Scheduler queue entries
    localparam int NMAC = 8;          // Macro-op tracking slots
    localparam int GROUP = 4;         // Macro-ops per dispatch group
    localparam int UOPS_PER_MOP = 2;  // Address uop plus execute uop
    localparam int NPIPE = 4;         // Two arith pipes, two addr_gen pipes
    localparam int MUL_STAGES = 3;    // Multiplier pipeline depth
    localparam int CNT_STAGES = 2;    // Bit-count pipeline depth
    localparam int NWB = 7;           // Result buses
    localparam int SEQW = 6;          // Age stamp width
    localparam int DIVW = 4;          // Divider extra-cycle field width
    // Pipe positions
    localparam int P_DIV = 0;         // divide_arith_pipe
    localparam int P_MUL = 1;         // multiply_arith_pipe
    // Result bus positions
    localparam int WB_MUL = 4;
    localparam int WB_CNT = 5;
    localparam int WB_DIV = 6;
    // Reset values
    localparam int NEXT_PHYS_RST = NARCH;
    localparam logic DISP_READY_RST = 1'b1;

    typedef logic [3:0] ise_areg_t;
    typedef logic [4:0] ise_preg_t;
    typedef logic [2:0] ise_tag_t;
    typedef logic [SEQW-1:0] ise_seq_t;
    typedef logic [1:0] ise_pend_t;
    typedef logic [DIVW-1:0] ise_dlen_t;

    typedef enum logic [2:0] {ISE_ALU, ISE_MUL, ISE_DIV, ISE_CNT, ISE_AGEN} ise_kind_t;

    // One macro-op as delivered by the dispatch stage
    typedef struct packed {
        logic valid;
        logic has_agen;
        logic has_exec;
        ise_kind_t kind;
        logic dst_wr;
        ise_areg_t dst;
        ise_areg_t src1;
        ise_areg_t src2;
        ise_dlen_t div_len;
    } ise_mop_t;

    typedef struct packed {
        ise_mop_t [GROUP-1:0] op;
    } ise_group_t;

    typedef struct packed {
        logic valid;
        ise_kind_t kind;
        ise_preg_t ps1;
        ise_preg_t ps2;
        ise_preg_t pd;
        logic pd_wr;
        ise_tag_t tag;
        ise_seq_t seq;
        ise_dlen_t div_len;
    } ise_uop_t;

    // Result bus beat
    typedef struct packed {
        logic valid;
        ise_preg_t pd;
        logic pd_wr;
        ise_tag_t tag;
    } ise_wb_t;

    typedef struct packed {
        ise_uop_t [NQ-1:0] q;
        logic [NPHYS-1:0] rdy;
        ise_preg_t [NARCH-1:0] map;
        ise_preg_t next_phys;
        ise_seq_t seq;
        ise_pend_t [NMAC-1:0] pend;
        logic [NMAC-1:0] busy_mac;
        ise_tag_t head;
        ise_wb_t [NPIPE-1:0] ex;
        ise_wb_t [MUL_STAGES-1:0] mul;
        ise_wb_t [CNT_STAGES-1:0] cnt;
        ise_wb_t div;
        ise_dlen_t div_cnt;
        logic disp_ready;
        logic [NMAC-1:0] retired;
    } ise_state_t;
endpackage

// ### ise_core.sv
// Integer scheduler with rename, oldest-first issue and four execution pipes
// Operation
// - accept one dispatch group of up to four macro-ops per cycle
// - split each macro-op into micro-ops inside the scheduler before issue
// - rename architectural registers to physical registers at dispatch
// - issue only with all sources ready, from register state or result bus
// - pick the oldest ready micro-op so waiting ones are not starved
// - micro-ops of one macro-op may issue out of program order
// - two arith pipes for all ALU work, two addr_gen pipes for address and ALU
// - a pipe pair runs two micro-ops of different macro-ops in one cycle
// - divide_arith_pipe holds a non-pipelined, variable latency divider
// - multiply_arith_pipe holds a fully pipelined multiplier
// - leading_zero_count and population_count use a pipeline on divide_arith_pipe
// - report macro-op completion once all its micro-ops have executed
// - scheduling driven only by operand validity, pipe availability, age and the pipe pair macro-op rule
`timescale 1ns/100ps
module ise_core (
    input wire logic clk,
    input wire logic rst,
    input wire logic disp_valid,
    input wire ise_pkg::ise_group_t disp_group,
    output logic disp_ready,
    output ise_pkg::ise_tag_t disp_tag,
    output logic [ise_pkg::NMAC-1:0] retire_done,
    output logic div_busy
);
    ise_pkg::ise_state_t s;
    ise_pkg::ise_state_t next_s;
    ise_pkg::ise_wb_t [ise_pkg::NWB-1:0] wb;
    ise_pkg::ise_wb_t w;
    ise_pkg::ise_mop_t m;
    ise_pkg::ise_tag_t t;
    logic acc;
    logic [ise_pkg::NQ-1:0] taken;
    logic [1:0] pv;
    ise_pkg::ise_tag_t [1:0] ptag;
    int pick [ise_pkg::NPIPE];
    int j;

    // Wrap-aware age compare; queue depth is far below half the stamp range
    function automatic logic older(ise_pkg::ise_seq_t a, ise_pkg::ise_seq_t b);
        ise_pkg::ise_seq_t d;
        d = a - b;
        return d[ise_pkg::SEQW-1];
    endfunction

    // Which micro-op kinds each pipe accepts
    function automatic logic can_go(ise_pkg::ise_kind_t k, int pp);
        case (pp)
            ise_pkg::P_DIV: return k inside {ise_pkg::ISE_ALU, ise_pkg::ISE_DIV, ise_pkg::ISE_CNT};
            ise_pkg::P_MUL: return k inside {ise_pkg::ISE_ALU, ise_pkg::ISE_MUL};
            default: return k inside {ise_pkg::ISE_ALU, ise_pkg::ISE_AGEN};
        endcase
    endfunction

    // Operand ready in the register state or being broadcast this cycle
    function automatic logic src_ok(ise_pkg::ise_preg_t p, logic [ise_pkg::NPHYS-1:0] r,
                                    ise_pkg::ise_wb_t [ise_pkg::NWB-1:0] b);
        logic hit;
        hit = r[p];
        for (int k = 0; k < ise_pkg::NWB; k++) begin
            hit = hit | (b[k].valid && b[k].pd_wr && b[k].pd == p);
        end
        return hit;
    endfunction

    function automatic int first_free(ise_pkg::ise_uop_t [ise_pkg::NQ-1:0] q);
        int f;
        f = -1;
        for (int i = ise_pkg::NQ - 1; i >= 0; i--) begin
            if (!q[i].valid) begin
                f = i;
            end
        end
        return f;
    endfunction

    function automatic int q_free(ise_pkg::ise_uop_t [ise_pkg::NQ-1:0] q);
        int c;
        c = 0;
        for (int i = 0; i < ise_pkg::NQ; i++) begin
            c = c + int'(!q[i].valid);
        end
        return c;
    endfunction

    function automatic logic slots_free(logic [ise_pkg::NMAC-1:0] b, ise_pkg::ise_tag_t h);
        logic ok;
        ok = 1'b1;
        for (int i = 0; i < ise_pkg::GROUP; i++) begin
            ok = ok & !b[ise_pkg::ise_tag_t'(h + ise_pkg::ise_tag_t'(i))];
        end
        return ok;
    endfunction

    function automatic ise_pkg::ise_state_t reset_state();
        ise_pkg::ise_state_t r;
        r = '0;
        r.rdy = '1;
        for (int a = 0; a < ise_pkg::NARCH; a++) begin
            r.map[a] = ise_pkg::ise_preg_t'(a);
        end
        r.next_phys = ise_pkg::ise_preg_t'(ise_pkg::NEXT_PHYS_RST);
        r.disp_ready = ise_pkg::DISP_READY_RST;
        return r;
    endfunction

    // Whole next state in one pass: result buses, issue, completion, dispatch
    always_comb begin
        next_s = s;
        acc = disp_valid && s.disp_ready;
        w = '0;
        m = '0;
        t = '0;
        j = 0;
        // Result buses feed both wakeup and same-cycle bypass
        for (int p = 0; p < ise_pkg::NPIPE; p++) begin
            wb[p] = s.ex[p];
        end
        wb[ise_pkg::WB_MUL] = s.mul[ise_pkg::MUL_STAGES-1];
        wb[ise_pkg::WB_CNT] = s.cnt[ise_pkg::CNT_STAGES-1];
        wb[ise_pkg::WB_DIV] = s.div;
        wb[ise_pkg::WB_DIV].valid = s.div.valid && s.div_cnt == '0;
        // Oldest-first select per pipe; arith pipes choose before their addr partner
        taken = '0;
        pv = '0;
        ptag = '0;
        for (int pp = 0; pp < ise_pkg::NPIPE; pp++) begin
            pick[pp] = -1;
            for (int i = 0; i < ise_pkg::NQ; i++) begin
                if (s.q[i].valid && !taken[i] && can_go(s.q[i].kind, pp)
                    && src_ok(s.q[i].ps1, s.rdy, wb) && src_ok(s.q[i].ps2, s.rdy, wb)
                    && !(s.q[i].kind == ise_pkg::ISE_DIV && s.div.valid)
                    && !(pp >= 2 && pv[pp%2] && ptag[pp%2] == s.q[i].tag)) begin
                    if (pick[pp] < 0 || older(s.q[i].seq, s.q[pick[pp]].seq)) begin
                        pick[pp] = i;
                    end
                end
            end
            if (pick[pp] >= 0) begin
                taken[pick[pp]] = 1'b1;
                if (pp < 2) begin
                    pv[pp] = 1'b1;
                    ptag[pp] = s.q[pick[pp]].tag;
                end
            end
        end
        // Advance execution stages; multiplier and bit-count shift every cycle
        next_s.ex = '0;
        next_s.mul = {s.mul[ise_pkg::MUL_STAGES-2:0], ise_pkg::ise_wb_t'(0)};
        next_s.cnt = {s.cnt[ise_pkg::CNT_STAGES-2:0], ise_pkg::ise_wb_t'(0)};
        if (s.div.valid) begin
            if (s.div_cnt == '0) begin
                next_s.div.valid = 1'b0;
            end else begin
                next_s.div_cnt = s.div_cnt - 1'b1;
            end
        end
        // Launch picked micro-ops, each independent of its siblings' order
        for (int pp = 0; pp < ise_pkg::NPIPE; pp++) begin
            if (pick[pp] >= 0) begin
                next_s.q[pick[pp]].valid = 1'b0;
                w = {1'b1, s.q[pick[pp]].pd, s.q[pick[pp]].pd_wr, s.q[pick[pp]].tag};
                case (s.q[pick[pp]].kind)
                    ise_pkg::ISE_MUL: next_s.mul[0] = w;
                    ise_pkg::ISE_CNT: next_s.cnt[0] = w;
                    ise_pkg::ISE_DIV: begin
                        next_s.div = w;
                        next_s.div_cnt = s.q[pick[pp]].div_len;
                    end
                    default: next_s.ex[pp] = w;
                endcase
            end
        end
        // Wakeup and per-macro bookkeeping
        for (int k = 0; k < ise_pkg::NWB; k++) begin
            if (wb[k].valid) begin
                if (wb[k].pd_wr) begin
                    next_s.rdy[wb[k].pd] = 1'b1;
                end
                next_s.pend[wb[k].tag] = next_s.pend[wb[k].tag] - 1'b1;
            end
        end
        next_s.retired = '0;
        for (int k = 0; k < ise_pkg::NMAC; k++) begin
            if (s.busy_mac[k] && next_s.pend[k] == '0) begin
                next_s.busy_mac[k] = 1'b0;
                next_s.retired[k] = 1'b1;
            end
        end
        // Dispatch: rename in slot order so later ops see earlier writers
        if (acc) begin
            for (int g = 0; g < ise_pkg::GROUP; g++) begin
                m = disp_group.op[g];
                t = ise_pkg::ise_tag_t'(s.head + ise_pkg::ise_tag_t'(g));
                if (m.valid) begin
                    w = {1'b0, next_s.next_phys, m.dst_wr && m.has_exec, t};
                    if (m.has_agen) begin
                        j = first_free(next_s.q);
                        next_s.q[j] = {1'b1, ise_pkg::ISE_AGEN, next_s.map[m.src1],
                            next_s.map[m.src2], w.pd, 1'b0, t, next_s.seq, m.div_len};
                        next_s.seq = next_s.seq + 1'b1;
                    end
                    if (m.has_exec) begin
                        j = first_free(next_s.q);
                        next_s.q[j] = {1'b1, m.kind, next_s.map[m.src1], next_s.map[m.src2],
                            w.pd, w.pd_wr, t, next_s.seq, m.div_len};
                        next_s.seq = next_s.seq + 1'b1;
                    end
                    if (w.pd_wr) begin
                        next_s.map[m.dst] = w.pd;
                        next_s.rdy[w.pd] = 1'b0;
                        next_s.next_phys = next_s.next_phys + 1'b1;
                    end
                    next_s.pend[t] = ise_pkg::ise_pend_t'(m.has_agen)
                        + ise_pkg::ise_pend_t'(m.has_exec);
                    next_s.busy_mac[t] = m.has_agen | m.has_exec;
                    next_s.retired[t] = !(m.has_agen | m.has_exec);
                end
            end
            next_s.head = ise_pkg::ise_tag_t'(s.head + ise_pkg::ise_tag_t'(ise_pkg::GROUP));
        end
        // Ready only when a full worst-case group fits, so a group is never split
        next_s.disp_ready = q_free(next_s.q) >= ise_pkg::GROUP * ise_pkg::UOPS_PER_MOP
            && slots_free(next_s.busy_mac, next_s.head);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s <= reset_state();
        end else begin
            s <= next_s;
        end
    end

    // Outputs straight from state
    assign disp_ready = s.disp_ready;
    assign disp_tag = s.head;
    assign retire_done = s.retired;
    assign div_busy = s.div.valid;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_group_room: assert property (acc |-> q_free(s.q) >= ise_pkg::GROUP * ise_pkg::UOPS_PER_MOP)
        else $error("group accepted without queue room");
    chk_split_count: assert property (acc && disp_group.op[0].valid
        && disp_group.op[0].has_agen && disp_group.op[0].has_exec
        |=> s.pend[$past(s.head)] == 2'h2 && s.busy_mac[$past(s.head)])
        else $error("macro-op not split into two micro-ops");
    chk_rename_new: assert property (acc && disp_group.op[3].valid
        && disp_group.op[3].dst_wr && disp_group.op[3].has_exec
        |=> !s.rdy[s.map[$past(disp_group.op[3].dst)]])
        else $error("renamed destination still marked ready");
    chk_issue_ready: assert property (pick[2] >= 0 |->
        src_ok(s.q[pick[2]].ps1, s.rdy, wb) && src_ok(s.q[pick[2]].ps2, s.rdy, wb))
        else $error("micro-op issued with source pending");
    chk_pair_macro: assert property (s.ex[0].valid && s.ex[2].valid |->
        s.ex[0].tag != s.ex[2].tag)
        else $error("pipe pair ran one macro-op twice");
    chk_div_hold: assert property (s.div.valid && s.div_cnt != '0 |=>
        s.div.valid && s.div.tag == $past(s.div.tag) && s.div_cnt == $past(s.div_cnt) - 1'b1)
        else $error("divider disturbed while busy");
    chk_mul_depth: assert property (s.mul[0].valid |->
        ##2 s.mul[2].valid && s.mul[2].pd == $past(s.mul[0].pd, 2))
        else $error("multiplier pipeline lost an operation");
    chk_cnt_depth: assert property (s.cnt[0].valid |=>
        s.cnt[1].valid && s.cnt[1].tag == $past(s.cnt[0].tag))
        else $error("bit-count pipeline lost an operation");
    chk_retire_free: assert property ((s.retired & s.busy_mac) == '0)
        else $error("slot reported done while still busy");

    cov_full_group: cover property (acc && disp_group.op[0].valid && disp_group.op[3].valid);
    cov_div_block: cover property (s.div.valid ##1 s.div.valid && s.ex[0].valid);
    cov_pair_issue: cover property (s.ex[0].valid && s.ex[2].valid && s.mul[0].valid);
    cov_multi_retire: cover property ($countones(s.retired) >= 2);
endmodule

// ### ise_disp_model.sv
// Dispatch stage and retire control partner for the integer scheduler
`timescale 1ns/100ps
module ise_disp_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic disp_ready,
    input wire ise_pkg::ise_tag_t disp_tag,
    input wire logic [ise_pkg::NMAC-1:0] retire_done,
    input wire logic div_busy,
    output logic disp_valid,
    output ise_pkg::ise_group_t disp_group
);
    ise_pkg::ise_group_t q[$];
    ise_pkg::ise_tag_t tg;
    int cyc = 0;
    int gap = 0;
    int idle = 0;
    int div_cyc = 0;
    int errs = 0;
    int acc_cyc[8];
    int ret_cyc[8];
    logic [7:0] outst = 8'h00;

    // Queue a group for the dispatch side to offer
    task automatic push(input ise_pkg::ise_group_t g);
        q.push_back(g);
    endtask

    // Offer groups, hold each until taken, log acceptance and retire cycles
    always @(posedge clk) begin
        if (rst) begin
            outst = 8'h00;
            disp_valid <= 1'b0;
            disp_group <= '0;
        end else begin
            if (div_busy) div_cyc++;
            // A pulse for a tag that is not in flight is a fault of the block
            for (int t = 0; t < 8; t++) begin
                if (retire_done[t] === 1'b1) begin
                    if (!outst[t]) errs++;
                    outst[t] = 1'b0;
                    ret_cyc[t] = cyc;
                end
            end
            if (disp_valid && disp_ready) begin
                for (int g = 0; g < 4; g++) begin
                    tg = disp_tag + 3'(g);
                    // An invalid slot burns its tag but never reports completion
                    if (disp_group.op[g].valid) begin
                        acc_cyc[tg] = cyc;
                        ret_cyc[tg] = -1;
                        outst[tg] = 1'b1;
                    end
                end
                void'(q.pop_front());
                idle = gap;
            end
            // Slow mode leaves gaps; a released group shows inverted junk
            if (q.size() != 0 && idle == 0) begin
                disp_valid <= 1'b1;
                disp_group <= q[0];
            end else begin
                disp_valid <= 1'b0;
                disp_group <= ~disp_group;
                if (idle > 0) idle--;
            end
        end
        cyc = cyc + 1;
    end
endmodule

// ### ise_core_tb.sv
// Self-checking testbench for the integer scheduler and execution cluster
`timescale 1ns/100ps
module ise_core_tb;
    localparam ise_pkg::ise_kind_t k_alu = ise_pkg::ISE_ALU;
    localparam ise_pkg::ise_kind_t k_mul = ise_pkg::ISE_MUL;
    localparam ise_pkg::ise_kind_t k_div = ise_pkg::ISE_DIV;
    localparam ise_pkg::ise_kind_t k_cnt = ise_pkg::ISE_CNT;
    logic clk;
    logic rst;
    logic disp_valid;
    ise_pkg::ise_group_t disp_group;
    logic disp_ready;
    ise_pkg::ise_tag_t disp_tag;
    logic [ise_pkg::NMAC-1:0] retire_done;
    logic div_busy;
    int failures = 0;
    int num_checks = 0;
    int ticks = 0;
    int tb_tag = 0;
    int b;
    // Valid slot with no micro-ops: it takes a tag and retires on the next cycle
    ise_pkg::ise_mop_t nop = 23'h40_0000;

    ise_core uut (.clk(clk), .rst(rst), .disp_valid(disp_valid), .disp_group(disp_group),
        .disp_ready(disp_ready), .disp_tag(disp_tag), .retire_done(retire_done),
        .div_busy(div_busy));
    ise_disp_model dm (.clk(clk), .rst(rst), .disp_ready(disp_ready), .disp_tag(disp_tag),
        .retire_done(retire_done), .div_busy(div_busy), .disp_valid(disp_valid),
        .disp_group(disp_group));

    // Free-running clock, 8 ns period
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: saw %0d expected %0d", $time, seen, exp);
        end
    endtask

    task automatic test_done;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Hang guard: the whole run needs well under this many cycles
    always @(posedge clk) begin
        ticks++;
        if (ticks == 5000) begin
            failures++;
            test_done;
        end
    end

    function automatic ise_pkg::ise_mop_t mk(input logic a, e, ise_pkg::ise_kind_t k,
        logic w, logic [3:0] d, s1, s2, dl);
        mk = {1'b1, a, e, k, w, d, s1, s2, dl};
    endfunction

    // Cycles from acceptance to completion pulse for one tag
    function automatic int lat(input int t);
        lat = dm.ret_cyc[t % 8] - dm.acc_cyc[t % 8];
    endfunction

    task automatic send(input ise_pkg::ise_mop_t o0, o1, o2, o3);
        ise_pkg::ise_group_t g;
        g.op[0] = o0;
        g.op[1] = o1;
        g.op[2] = o2;
        g.op[3] = o3;
        dm.push(g);
        tb_tag = (tb_tag + 4) % 8;
    endtask

    // Wait, bounded, until every offered group is taken and has retired
    task automatic drain;
        int n;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while ((dm.q.size() != 0 || dm.outst !== 8'h00) && n < 300);
        check(n < 300, 1);
    endtask

    task automatic t_reset;
        check(disp_ready, 1);
        check(disp_tag, 0);
        check(retire_done, 0);
        check(div_busy, 0);
    endtask

    // Single ALU op; empty slots still consume a tag and retire at once
    task automatic t_walk;
        b = tb_tag;
        send(mk(0, 1, k_alu, 1, 4'h1, 4'h2, 4'h3, 4'h0), nop, nop, nop);
        drain;
        check(lat(b), 3);
        for (int g = 1; g < 4; g++) check(lat(b + g), 1);
        check(disp_tag, tb_tag);
    endtask

    // Agen-only, exec-only and split ops side by side; slow dispatch side
    task automatic t_split;
        dm.gap = 2;
        b = tb_tag;
        for (int r = 0; r < 2; r++) begin
            send(mk(1, 1, k_alu, 1, 4'h4, 4'h1, 4'h2, 4'h0), mk(1, 0, k_alu, 0, 4'h0, 4'h3,
                4'h3, 4'h0), mk(0, 1, k_alu, 1, 4'h5, 4'h2, 4'h1, 4'h0), nop);
        end
        drain;
        dm.gap = 0;
        check(dm.acc_cyc[(b + 4) % 8] - dm.acc_cyc[b], 3);
        for (int g = 0; g < 8; g++) check(lat(b + g), (g % 4 == 3) ? 1 : 3);
    endtask

    // Full group of eight micro-ops spread over four pipes in two cycles
    task automatic t_full;
        b = tb_tag;
        send(mk(1, 1, k_alu, 1, 4'h1, 4'h2, 4'h3, 4'h0), mk(1, 1, k_alu, 1, 4'h2, 4'h3, 4'h4,
            4'h0), mk(1, 1, k_alu, 1, 4'h3, 4'h4, 4'h5, 4'h0), mk(1, 1, k_alu, 1, 4'h4, 4'h5,
            4'h6, 4'h0));
        drain;
        for (int g = 0; g < 4; g++) check(lat(b + g) <= 4, 1);
    endtask

    // Dependency chain through bypass, then a rename that hides a slow writer
    task automatic t_dep;
        b = tb_tag;
        send(mk(0, 1, k_mul, 1, 4'h5, 4'h1, 4'h2, 4'h0), mk(0, 1, k_alu, 1, 4'h6, 4'h5, 4'h1,
            4'h0), mk(0, 1, k_cnt, 1, 4'h7, 4'h6, 4'h6, 4'h0), nop);
        drain;
        check(lat(b), 5);
        check(lat(b + 1), 6);
        check(lat(b + 2), 8);
        b = tb_tag;
        send(mk(0, 1, k_mul, 1, 4'h8, 4'h1, 4'h2, 4'h0), mk(0, 1, k_alu, 1, 4'h8, 4'h1, 4'h1,
            4'h0), mk(0, 1, k_alu, 1, 4'h9, 4'h8, 4'h8, 4'h0), nop);
        drain;
        check(lat(b + 2), 4);
        check(lat(b), 5);
    endtask

    // Four multiplies back to back, oldest first, one per cycle
    task automatic t_mul;
        b = tb_tag;
        send(mk(0, 1, k_mul, 1, 4'hA, 4'h1, 4'h2, 4'h0), mk(0, 1, k_mul, 1, 4'hB, 4'h1, 4'h2,
            4'h0), mk(0, 1, k_mul, 1, 4'hC, 4'h1, 4'h2, 4'h0), mk(0, 1, k_mul, 1, 4'hD, 4'h1,
            4'h2, 4'h0));
        drain;
        for (int g = 0; g < 4; g++) check(lat(b + g), 5 + g);
    endtask

    // Divider occupancy, serialised divides, ALU work passing a busy divider
    task automatic t_div;
        dm.div_cyc = 0;
        send(mk(0, 1, k_div, 1, 4'hA, 4'h1, 4'h2, 4'h5), nop, nop, nop);
        drain;
        check(dm.div_cyc, 6);
        dm.div_cyc = 0;
        b = tb_tag;
        send(mk(0, 1, k_div, 1, 4'hB, 4'h1, 4'h2, 4'h3), mk(0, 1, k_div, 1, 4'hC, 4'h1, 4'h2,
            4'h3), mk(0, 1, k_alu, 1, 4'hD, 4'h1, 4'h2, 4'h0), nop);
        drain;
        check(dm.div_cyc, 8);
        check(dm.ret_cyc[(b + 1) % 8] - dm.ret_cyc[b] >= 4, 1);
        check(lat(b + 2), 3);
    endtask

    // Back-to-back groups, then a refused group while one of its tags is busy
    task automatic t_refuse;
        b = tb_tag;
        send(mk(0, 1, k_div, 1, 4'hE, 4'h1, 4'h2, 4'hF), nop, nop, nop);
        send(mk(0, 1, k_alu, 1, 4'h1, 4'h2, 4'h2, 4'h0), nop, nop, nop);
        send(mk(0, 1, k_alu, 1, 4'h2, 4'h3, 4'h3, 4'h0), nop, nop, nop);
        drain;
        check(dm.acc_cyc[(b + 4) % 8] - dm.acc_cyc[(b + 5) % 8], 0);
        check(dm.acc_cyc[b] - dm.acc_cyc[(b + 4) % 8] >= 16, 1);
        check(lat(b), 3);
    endtask

    // Main sequence: reset for ten cycles, then each scenario in turn
    initial begin
        rst = 1'b1;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        t_reset;
        t_walk;
        t_split;
        t_full;
        t_dep;
        t_mul;
        t_div;
        t_refuse;
        check(dm.errs, 0);
        test_done;
    end
endmodule
